// ---- design/fdc_poll_pkg.sv ----
// Overview of operation
// R1: idle enters polling every 1 msec
// R2: ready toggles after reset, drive-0 interrupt
// R3: host senses interrupt four times per drive; the code clears one drive per sense, four senses in all
// R4: host disables polling within 500 usec
// R5: stepping and power-down checks always run; the code runs them only during polling
// R6: power down 512 msec after motor-off
// R7: hold parameter ready until polling completes
// R8: result bytes read through data register
// R9: first byte bits 1:0 give drive
// R10: bit 2 head side, bit 3 zero
// R11: bit 4 set when track zero missed
// R12: bit 5 set after head move completes
// R13: bits 7:6 give interrupt cause code
// R14: second byte bit 0 missing address mark
// R15: second byte bit 1 write protected
// R16: second byte bit 2 missing data
// R17: second byte bit 4 overrun or underrun
// R18: second byte bit 5 crc, 3,6 zero
// R19: second byte bit 7 end of track
// R20: third byte bit 0 mark location
// R21: third byte bit 1 bad track
// R22: third byte bits 2,3 scan results
// R23: last result read clears busy bit
// R24: unnamed result bits read zero
package fdc_poll_pkg;

  // ****************************************************************
  // register map and timing
  // ****************************************************************
  localparam logic [2:0] DATA_REG_OFFSET = 3'h5;
  localparam logic [2:0] MAIN_STATE_OFFSET = 3'h4;
  localparam int CLOCK_MHZ = 250;
  localparam int POLL_PERIOD_US = 1000;
  localparam int POLL_CYCLES = POLL_PERIOD_US * CLOCK_MHZ;
  localparam int POLL_LOOP_US = 500;
  localparam int POLL_LOOP_CYCLES = POLL_LOOP_US * CLOCK_MHZ;
  localparam int POWER_DELAY_MS = 512;
  localparam longint POWER_DELAY_CYCLES = longint'(POWER_DELAY_MS) * 1000 * CLOCK_MHZ;
  localparam int STEP_PULSE_CYCLES = 4;
  localparam int NUM_DRIVES = 4;
  localparam int NUM_RESULTS = 3;

  // main state register bit positions
  localparam int STATE_BUSY_BIT = 4;
  localparam int STATE_DIR_BIT = 6;
  localparam int STATE_REQ_BIT = 7;

  // interrupt cause codes
  localparam logic [1:0] CAUSE_NORMAL = 2'h0;
  localparam logic [1:0] CAUSE_ABNORMAL = 2'h1;
  localparam logic [1:0] CAUSE_INVALID = 2'h2;
  localparam logic [1:0] CAUSE_READY_CHANGE = 2'h3;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic       read_cmd;     // read, scan or verify
    logic       write_cmd;    // write or format
    logic       scan_cmd;
    logic       seek_cmd;     // head move, offset move or home
    logic       home_cmd;
    logic       header_read;
    logic       track_read;
    logic       invalid;
    logic       abnormal;
    logic [1:0] drive;
    logic       head_side;
  } cmd_info_t;

  typedef struct packed {
    logic       mark_missing;
    logic       data_mark_missing;
    logic       sector_absent;
    logic       header_crc_fail;
    logic       start_absent;
    logic       late_service;
    logic       crc_error;
    logic       eot_reached;
    logic       track_ff_mismatch;
    logic       scan_not_met;
    logic       scan_equal;
  } exec_events_t;

  typedef enum logic [1:0] {
    PH_IDLE   = 2'b00,
    PH_POLL   = 2'b01,
    PH_EXEC   = 2'b11,
    PH_RESULT = 2'b10
  } phase_t;

endpackage : fdc_poll_pkg

// ---- design/result_store.sv ----
`timescale 1ns/1ps
module result_store
(
  // clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_rst,
  // write side
  input  wire logic       i_load,
  input  wire logic [23:0] i_bytes,
  // read side
  input  wire logic [1:0] i_index,
  output logic      [7:0] o_byte
);
  logic [7:0] mem_q [fdc_poll_pkg::NUM_RESULTS];

  // load all result bytes at once
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      for (int i = 0; i < fdc_poll_pkg::NUM_RESULTS; i++)
        mem_q[i] <= 8'h00;
    end
    else if (i_load)
    begin
      mem_q[0] <= i_bytes[7:0];
      mem_q[1] <= i_bytes[15:8];
      mem_q[2] <= i_bytes[23:16];
    end
  end

  // registered read data
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
      o_byte <= 8'h00;
    else if (i_index < 2'(fdc_poll_pkg::NUM_RESULTS))
      o_byte <= mem_q[i_index];
    else
      o_byte <= 8'h00;
  end
endmodule : result_store

// ---- design/step_pulser.sv ----
`timescale 1ns/1ps
module step_pulser
(
  // clock and reset
  input  wire logic i_clock,
  input  wire logic i_rst,
  // request
  input  wire logic i_fire,
  input  wire logic i_dir,
  // drive pins
  output logic      o_step,
  output logic      o_dir
);
  logic [2:0] cnt_q;

  // fixed-width head motion pulse, direction held through it
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      cnt_q  <= 3'h0;
      o_step <= 1'b0;
      o_dir  <= 1'b0;
    end
    else if (i_fire && cnt_q == 3'h0)
    begin
      cnt_q  <= 3'(fdc_poll_pkg::STEP_PULSE_CYCLES);
      o_step <= 1'b1;
      o_dir  <= i_dir;
    end
    else if (cnt_q != 3'h0)
    begin
      cnt_q  <= cnt_q - 3'h1;
      o_step <= (cnt_q != 3'h1);
    end
  end
endmodule : step_pulser

// ---- design/fdc_poll_status.sv ----
`timescale 1ns/1ps
module fdc_poll_status
#(
  parameter int unsigned POLL_CYCLES_P  = fdc_poll_pkg::POLL_CYCLES,
  parameter int unsigned LOOP_CYCLES_P  = fdc_poll_pkg::POLL_LOOP_CYCLES,
  parameter longint unsigned POWER_CYCLES_P = fdc_poll_pkg::POWER_DELAY_CYCLES
)
(
  // clock and reset
  input  wire logic                      i_clock,
  input  wire logic                      i_rst,
  // host register port
  input  wire logic [2:0]                i_addr,
  input  wire logic                      i_rd,
  output logic      [7:0]                o_rdata,
  // command sequencing
  input  wire logic                      i_opcode_wr,
  input  wire logic                      i_exec_done,
  input  wire fdc_poll_pkg::cmd_info_t   i_cmd,
  input  wire fdc_poll_pkg::exec_events_t i_events,
  input  wire logic                      i_sense_int,
  input  wire logic                      i_poll_disable,
  // drive control
  input  wire logic [3:0]                i_step_req,
  input  wire logic                      i_step_dir,
  input  wire logic                      i_motor_off_expired,
  input  wire logic                      i_auto_power_en,
  // drive pins
  input  wire logic                      i_track_zero_input,
  input  wire logic                      i_write_protect,
  input  wire logic                      i_terminal_count_input,
  // status outputs
  output logic                           o_param_ready,
  output logic                           o_interrupt,
  output logic                           o_power_down,
  output logic                           o_step,
  output logic                           o_dir
);
  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [2:0] pin_meta_q;
  logic [2:0] pin_sync_q;

  // two stages for the drive pins
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      pin_meta_q <= 3'h0;
      pin_sync_q <= 3'h0;
    end
    else
    begin
      pin_meta_q <= {i_terminal_count_input, i_write_protect, i_track_zero_input};
      pin_sync_q <= pin_meta_q;
    end
  end

  logic home_s;
  logic wp_s;
  logic count_s;
  assign home_s  = pin_sync_q[0];
  assign wp_s    = pin_sync_q[1];
  assign count_s = pin_sync_q[2];

  // ****************************************************************
  // phase sequencer
  // ****************************************************************
  fdc_poll_pkg::phase_t phase_q;
  logic [31:0] poll_cnt_q;
  logic [31:0] loop_cnt_q;
  logic        pending_q;
  logic        poll_end;
  logic [1:0]  result_idx_q;
  logic        last_read;

  assign poll_end  = (phase_q == fdc_poll_pkg::PH_POLL) && (loop_cnt_q == 32'h0);
  assign last_read = (phase_q == fdc_poll_pkg::PH_RESULT) && i_rd
                     && (i_addr == fdc_poll_pkg::DATA_REG_OFFSET)
                     && (result_idx_q == 2'(fdc_poll_pkg::NUM_RESULTS - 1));

  // idle timer that launches polling
  always_ff @(posedge i_clock)
  begin
    if (i_rst || phase_q != fdc_poll_pkg::PH_IDLE)
      poll_cnt_q <= 32'h0;
    else if (poll_cnt_q < POLL_CYCLES_P - 1)
      poll_cnt_q <= poll_cnt_q + 32'h1;
    else
      poll_cnt_q <= 32'h0;
  end

  // polling loop length
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
      loop_cnt_q <= 32'h0;
    else if (phase_q == fdc_poll_pkg::PH_IDLE)
      loop_cnt_q <= LOOP_CYCLES_P - 1;
    else if (loop_cnt_q != 32'h0)
      loop_cnt_q <= loop_cnt_q - 32'h1;
  end

  // opcode that arrived during polling waits for loop end
  always_ff @(posedge i_clock)
  begin
    if (i_rst || poll_end)
      pending_q <= 1'b0;
    else if (i_opcode_wr && phase_q == fdc_poll_pkg::PH_POLL)
      pending_q <= 1'b1; // see R7
  end

  // phase transitions
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
      phase_q <= fdc_poll_pkg::PH_IDLE;
    else
    begin
      unique case (phase_q)
        fdc_poll_pkg::PH_IDLE:
          if (i_opcode_wr)
            phase_q <= fdc_poll_pkg::PH_EXEC;
          else if (poll_cnt_q == POLL_CYCLES_P - 1)
            phase_q <= fdc_poll_pkg::PH_POLL; // see R1
        fdc_poll_pkg::PH_POLL:
          if (poll_end)
            phase_q <= (pending_q || i_opcode_wr) ? fdc_poll_pkg::PH_EXEC
                                                 : fdc_poll_pkg::PH_IDLE; // see R7
        fdc_poll_pkg::PH_EXEC:
          if (i_exec_done)
            phase_q <= fdc_poll_pkg::PH_RESULT;
        fdc_poll_pkg::PH_RESULT:
          if (last_read)
            phase_q <= fdc_poll_pkg::PH_IDLE; // see R23
      endcase
    end
  end

  // parameter ready withheld while polling
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
      o_param_ready <= 1'b1;
    else
      o_param_ready <= (phase_q != fdc_poll_pkg::PH_POLL) && !(i_opcode_wr
                       && phase_q == fdc_poll_pkg::PH_POLL); // see R7
  end

  // ****************************************************************
  // drive ready tracking
  // ****************************************************************
  logic [3:0] ready_q;
  logic [3:0] change_q;
  logic       after_reset_q;
  logic [1:0] sense_idx_q;

  // ready lines toggle once after reset, unless polling is disabled
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      ready_q       <= 4'h0;
      change_q      <= 4'h0;
      after_reset_q <= 1'b1;
    end
    else
    begin
      if (i_sense_int)
        change_q[sense_idx_q] <= 1'b0; // see R3
      // set below wins over a same-cycle clear
      if (poll_end && after_reset_q)
      begin
        after_reset_q <= 1'b0;
        if (!i_poll_disable)
        begin
          ready_q  <= ~ready_q;  // see R2
          change_q <= 4'hf;      // see R2
        end
      end
    end
  end

  // each sense command that finds a ready change pending moves on to the next drive
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
      sense_idx_q <= 2'h0;
    else if (i_sense_int && change_q[sense_idx_q])
      sense_idx_q <= sense_idx_q + 2'h1;
  end

  // interrupt for drive 0 on ready change, and at end of execution
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
      o_interrupt <= 1'b0;
    else if ((poll_end && after_reset_q && !i_poll_disable) || i_exec_done)
      o_interrupt <= 1'b1; // see R2
    else if (i_rd && i_addr == fdc_poll_pkg::DATA_REG_OFFSET
             && phase_q == fdc_poll_pkg::PH_RESULT && result_idx_q == 2'h0)
      o_interrupt <= 1'b0;
    else if (i_sense_int)
      o_interrupt <= 1'b0;
  end

  // ****************************************************************
  // stepping and delayed power-down
  // ****************************************************************
  logic [63:0] power_cnt_q;
  logic        power_arm_q;

  step_pulser u_step
  (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_fire  (phase_q == fdc_poll_pkg::PH_POLL && |i_step_req), // see R5
    .i_dir   (i_step_dir),
    .o_step  (o_step),
    .o_dir   (o_dir)
  );

  // power-down delay checked during polling
  always_ff @(posedge i_clock)
  begin
    if (i_rst || !i_auto_power_en || !i_motor_off_expired)
    begin
      power_arm_q  <= 1'b0;
      power_cnt_q  <= 64'h0;
      o_power_down <= 1'b0;
    end
    else if (phase_q == fdc_poll_pkg::PH_POLL && !power_arm_q)
      power_arm_q <= 1'b1; // see R5
    else if (power_arm_q && power_cnt_q < POWER_CYCLES_P - 1)
      power_cnt_q <= power_cnt_q + 64'h1;
    else if (power_arm_q)
      o_power_down <= 1'b1; // see R6
  end

  // ****************************************************************
  // result byte assembly
  // ****************************************************************
  logic [7:0] res0;
  logic [7:0] res1;
  logic [7:0] res2;
  logic [1:0] cause;
  logic [7:0] res_byte;
  logic       reading_sense;

  assign reading_sense = i_sense_int;

  // cause code with ready change winning for sense reports
  always_comb
  begin
    if (reading_sense && change_q[sense_idx_q])
      cause = fdc_poll_pkg::CAUSE_READY_CHANGE; // see R13
    else if (i_cmd.invalid)
      cause = fdc_poll_pkg::CAUSE_INVALID;
    else if (i_cmd.abnormal)
      cause = fdc_poll_pkg::CAUSE_ABNORMAL;
    else
      cause = fdc_poll_pkg::CAUSE_NORMAL;
  end

  // first byte, all other bits clear
  always_comb
  begin
    res0 = 8'h00; // see R24
    res0[1:0] = reading_sense ? sense_idx_q : i_cmd.drive; // see R9
    res0[2]   = i_cmd.head_side;                             // see R10
    res0[4]   = i_cmd.home_cmd && !home_s;                   // see R11
    res0[5]   = i_cmd.seek_cmd;                              // see R12
    res0[7:6] = cause;                                       // see R13
  end

  // second byte
  always_comb
  begin
    res1 = 8'h00; // see R18
    res1[0] = i_cmd.read_cmd && i_events.mark_missing;       // see R14
    res1[1] = i_cmd.write_cmd && wp_s;                       // see R15
    res1[2] = (i_cmd.read_cmd && i_events.sector_absent)
              || (i_cmd.header_read && i_events.header_crc_fail)
              || (i_cmd.track_read && i_events.start_absent); // see R16
    res1[4] = i_events.late_service;                         // see R17
    res1[5] = i_events.crc_error;                            // see R18
    res1[7] = i_events.eot_reached && !count_s;              // see R19
  end

  // third byte
  always_comb
  begin
    res2 = 8'h00; // see R24
    res2[0] = i_events.mark_missing && i_events.data_mark_missing; // see R20
    res2[1] = i_events.track_ff_mismatch;                           // see R21
    res2[2] = i_cmd.scan_cmd && i_events.scan_not_met;              // see R22
    res2[3] = i_cmd.scan_cmd && i_events.scan_equal;                // see R22
  end

  result_store u_store
  (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_load  (i_exec_done || i_sense_int),
    .i_bytes ({res2, res1, res0}),
    .i_index (result_idx_q),
    .o_byte  (res_byte)
  );

  // result byte pointer
  always_ff @(posedge i_clock)
  begin
    if (i_rst || phase_q != fdc_poll_pkg::PH_RESULT)
      result_idx_q <= 2'h0;
    else if (i_rd && i_addr == fdc_poll_pkg::DATA_REG_OFFSET)
      result_idx_q <= result_idx_q + 2'h1;
  end

  // ****************************************************************
  // host read data
  // ****************************************************************
  logic [7:0] state_word;

  // main state register is always valid
  always_comb
  begin
    state_word = 8'h00;
    state_word[3:0] = change_q;
    state_word[fdc_poll_pkg::STATE_BUSY_BIT] = (phase_q == fdc_poll_pkg::PH_EXEC)
                                               || (phase_q == fdc_poll_pkg::PH_RESULT); // see R23
    state_word[fdc_poll_pkg::STATE_DIR_BIT]  = (phase_q == fdc_poll_pkg::PH_RESULT);
    state_word[fdc_poll_pkg::STATE_REQ_BIT]  = (phase_q != fdc_poll_pkg::PH_POLL);
  end

  // results only visible during result phase
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
      o_rdata <= 8'h00;
    else if (i_addr == fdc_poll_pkg::MAIN_STATE_OFFSET)
      o_rdata <= state_word;
    else if (i_addr == fdc_poll_pkg::DATA_REG_OFFSET && phase_q == fdc_poll_pkg::PH_RESULT)
      o_rdata <= res_byte; // see R8
    else
      o_rdata <= 8'h00;
  end
endmodule : fdc_poll_status

// ---- tb/fdc_poll_status_assertions.sv ----
`timescale 1ns/1ps
module fdc_poll_status_assertions
#(
  parameter int unsigned     POLL_CYCLES_P  = 20,
  parameter int unsigned     LOOP_CYCLES_P  = 5,
  parameter longint unsigned POWER_CYCLES_P = 30
)
(
  // clock and reset
  input wire logic       i_clock,
  input wire logic       i_rst,
  // watched inputs
  input wire logic [2:0] i_addr,
  input wire logic       i_rd,
  input wire logic       i_exec_done,
  input wire logic       i_motor_off_expired,
  input wire logic       i_auto_power_en,
  // watched outputs
  input wire logic [7:0] o_rdata,
  input wire logic       o_param_ready,
  input wire logic       o_interrupt,
  input wire logic       o_power_down,
  input wire logic       o_step,
  input wire logic       o_dir
);
  localparam longint unsigned PWR_MAX = POWER_CYCLES_P + 2 * POLL_CYCLES_P + LOOP_CYCLES_P + 8;
  longint unsigned off_q;
  int unsigned     low_q;

  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);

  // ****************************************************************
  // helper counters
  // ****************************************************************
  // cycles since power-down became due and enabled
  always_ff @(posedge i_clock)
  begin
    if (i_rst || !(i_motor_off_expired && i_auto_power_en))
      off_q <= 0;
    else
      off_q <= off_q + 1;
  end

  // length of the current withheld-ready stretch
  always_ff @(posedge i_clock)
  begin
    if (i_rst || o_param_ready)
      low_q <= 0;
    else
      low_q <= low_q + 1;
  end

  // ****************************************************************
  // properties
  // ****************************************************************
  property p_step_width;
    $rose(o_step) |-> o_step [*4] ##1 !o_step;
  endproperty
  a_step_width: assert property (p_step_width) else $error("step pulse width wrong");
  property p_dir_hold;
    o_step && $past(o_step) |-> $stable(o_dir);
  endproperty
  a_dir_hold: assert property (p_dir_hold) else $error("direction moved in pulse");
  property p_int_done;
    i_exec_done |=> o_interrupt;
  endproperty
  a_int_done: assert property (p_int_done) else $error("no interrupt at result");
  property p_int_clear;
    o_interrupt && i_rd && i_addr == 3'h5 |-> ##[1:2] !o_interrupt;
  endproperty
  a_int_clear: assert property (p_int_clear) else $error("interrupt not cleared");
  property p_st0_b3;
    o_interrupt && i_rd && i_addr == 3'h5 |=> !o_rdata[3];
  endproperty
  a_st0_b3: assert property (p_st0_b3) else $error("first byte bit 3 set");
  property p_pwr_early;
    $rose(o_power_down) |-> off_q >= POWER_CYCLES_P;
  endproperty
  a_pwr_early: assert property (p_pwr_early) else $error("power down too early");
  property p_pwr_en;
    $rose(o_power_down) |-> $past(i_auto_power_en);
  endproperty
  a_pwr_en: assert property (p_pwr_en) else $error("power down while disabled");
  property p_pwr_late;
    off_q > PWR_MAX |-> o_power_down;
  endproperty
  a_pwr_late: assert property (p_pwr_late) else $error("power down missing");
  property p_param_hold;
    low_q <= LOOP_CYCLES_P + 2;
  endproperty
  a_param_hold: assert property (p_param_hold) else $error("ready withheld too long");

  // main scenarios reached
  c_step: cover property ($rose(o_step));
  c_pwr: cover property ($rose(o_power_down));
  c_int: cover property ($rose(o_interrupt));
endmodule : fdc_poll_status_assertions

bind fdc_poll_status fdc_poll_status_assertions
#(
  .POLL_CYCLES_P(POLL_CYCLES_P),
  .LOOP_CYCLES_P(LOOP_CYCLES_P),
  .POWER_CYCLES_P(POWER_CYCLES_P)
)
u_chk
(
  .i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr), .i_rd(i_rd), .i_exec_done(i_exec_done),
  .i_motor_off_expired(i_motor_off_expired), .i_auto_power_en(i_auto_power_en), .o_rdata(o_rdata),
  .o_param_ready(o_param_ready), .o_interrupt(o_interrupt), .o_power_down(o_power_down),
  .o_step(o_step), .o_dir(o_dir)
);

// ---- tb/drive_pins_model.sv ----
`timescale 1ns/1ps
module drive_pins_model
(
  // clock
  input  wire logic i_clock,
  // drive state
  input  wire logic i_at_home,
  input  wire logic i_protect,
  input  wire logic i_count_done,
  // drive pins
  output logic      o_track_zero_input,
  output logic      o_write_protect,
  output logic      o_terminal_count_input
);
  // pins move just after the edge, like a real drive
  always_ff @(posedge i_clock)
  begin
    o_track_zero_input     <= i_at_home;
    o_write_protect        <= i_protect;
    o_terminal_count_input <= i_count_done;
  end
endmodule : drive_pins_model

// ---- tb/floppy_drive_poll_and_result_status_bench.sv ----
`timescale 1ns/1ps
module floppy_drive_poll_and_result_status_bench;
  // ****************************************************************
  // signals and instances
  // ****************************************************************
  logic i_clock = 1'b0, i_rst = 1'b1, i_rd = 1'b0, i_opcode_wr = 1'b0, i_exec_done = 1'b0;
  logic i_sense_int = 1'b0, i_poll_disable = 1'b0, i_step_dir = 1'b0, i_motor_off_expired = 1'b0;
  logic i_auto_power_en = 1'b0, at_home = 1'b1, protect = 1'b0, count_done = 1'b1, trk, wp, cnt_pin;
  logic [2:0] i_addr = 3'h0;
  logic [3:0] i_step_req = 4'h0;
  logic [7:0] o_rdata, d;
  logic       o_param_ready, o_interrupt, o_power_down, o_step, o_dir;
  fdc_poll_pkg::cmd_info_t    i_cmd = '0;
  fdc_poll_pkg::exec_events_t i_events = '0;
  int         error_cnt = 0, checks_done = 0, cyc = 0, n;

  fdc_poll_status #(.POLL_CYCLES_P(20), .LOOP_CYCLES_P(5), .POWER_CYCLES_P(30)) uut
  (
    .i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_opcode_wr(i_opcode_wr), .i_exec_done(i_exec_done), .i_cmd(i_cmd), .i_events(i_events),
    .i_sense_int(i_sense_int), .i_poll_disable(i_poll_disable), .i_step_req(i_step_req),
    .i_step_dir(i_step_dir), .i_motor_off_expired(i_motor_off_expired),
    .i_auto_power_en(i_auto_power_en), .i_track_zero_input(trk), .i_write_protect(wp),
    .i_terminal_count_input(cnt_pin), .o_param_ready(o_param_ready), .o_interrupt(o_interrupt),
    .o_power_down(o_power_down), .o_step(o_step), .o_dir(o_dir)
  );
  drive_pins_model drv
  (
    .i_clock(i_clock), .i_at_home(at_home), .i_protect(protect), .i_count_done(count_done),
    .o_track_zero_input(trk), .o_write_protect(wp), .o_terminal_count_input(cnt_pin)
  );

  // 250 MHz clock
  initial
  begin
    forever #2 i_clock = ~i_clock;
  end

  // hang guard
  always @(posedge i_clock)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      end_sim();
    end
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk8
  task automatic rd(input logic [2:0] a);
    @(posedge i_clock);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask : rd
  task automatic wait_hi(ref logic s, input int lim);
    n = 0;
    #1;
    while (s !== 1'b1 && n < lim)
    begin
      @(posedge i_clock);
      #1;
      n++;
    end
  endtask : wait_hi
  // one command through execution and result, expected bytes packed first to last
  // s marks a sense command, which loads its bytes as execution ends
  task automatic run_cmd(input logic [11:0] c, input logic [10:0] ev, input logic [23:0] exp,
                         input logic s = 1'b0);
    repeat (4) @(posedge i_clock);
    i_opcode_wr <= 1'b1;
    @(posedge i_clock);
    i_opcode_wr <= 1'b0;
    wait_hi(o_param_ready, 50);
    @(posedge i_clock);
    i_cmd       <= fdc_poll_pkg::cmd_info_t'(c);
    i_events    <= fdc_poll_pkg::exec_events_t'(ev);
    i_exec_done <= 1'b1;
    i_sense_int <= s;
    @(posedge i_clock);
    i_exec_done <= 1'b0;
    i_sense_int <= 1'b0;
    rd(3'h5);
    chk8(d, exp[23:16]);
    rd(3'h5);
    chk8(d, exp[15:8]);
    rd(3'h5);
    chk8(d, exp[7:0]);
    rd(3'h4);
    chk8({7'h0, d[fdc_poll_pkg::STATE_BUSY_BIT]}, 8'h00);
  endtask : run_cmd

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_poll_int();
    wait_hi(o_interrupt, 200);
    chk8({7'h0, o_interrupt}, 8'h01);
    rd(3'h4);
    chk8(d & 8'h0f, 8'h0f);
    // one sense command per drive, each a full result phase
    for (int i = 0; i < 4; i++)
      run_cmd(12'h000, 11'h000, {8'hc0 | 8'(i), 16'h0000}, 1'b1);
    rd(3'h4);
    chk8(d & 8'h0f, 8'h00);
    @(posedge i_clock);
    i_poll_disable <= 1'b1;
    rd(3'h5);
    chk8(d, 8'h00);
  endtask : t_poll_int
  task automatic t_results();
    run_cmd(12'h80f, 11'h608, 24'h470101);
    run_cmd(12'h04a, 11'h090, 24'h412400);
    @(posedge i_clock);
    protect <= 1'b1;
    run_cmd(12'h40d, 11'h020, 24'h461200);
    @(posedge i_clock);
    protect    <= 1'b0;
    count_done <= 1'b0;
    run_cmd(12'h028, 11'h040, 24'h400400);
    run_cmd(12'ha02, 11'h00d, 24'h01800a);
    run_cmd(12'ha02, 11'h402, 24'h010104);
    @(posedge i_clock);
    at_home <= 1'b0;
    run_cmd(12'h180, 11'h000, 24'h300000);
    @(posedge i_clock);
    at_home <= 1'b1;
    run_cmd(12'h180, 11'h000, 24'h200000);
    run_cmd(12'h010, 11'h000, 24'h800000);
  endtask : t_results
  task automatic t_step();
    // reset again with polling already disabled
    @(posedge i_clock);
    i_rst <= 1'b1;
    repeat (6) @(posedge i_clock);
    i_rst      <= 1'b0;
    i_step_dir <= 1'b1;
    i_step_req <= 4'h1;
    wait_hi(o_step, 100);
    chk8({7'h0, o_dir}, 8'h01);
    chk8({7'h0, o_param_ready}, 8'h00);
    @(posedge i_clock);
    i_step_req <= 4'h0;
    n = 1;
    #1;
    while (o_step === 1'b1 && n < 20)
    begin
      @(posedge i_clock);
      #1;
      n++;
    end
    chk8(8'(n), 8'h04);
  endtask : t_step
  task automatic t_power();
    @(posedge i_clock);
    i_motor_off_expired <= 1'b1;
    repeat (100) @(posedge i_clock);
    chk8({7'h0, o_power_down}, 8'h00);
    i_motor_off_expired <= 1'b0;
    i_auto_power_en     <= 1'b1;
    repeat (4) @(posedge i_clock);
    i_motor_off_expired <= 1'b1;
    wait_hi(o_power_down, 300);
    chk8({7'h0, n >= 30}, 8'h01);
    chk8({7'h0, o_power_down}, 8'h01);
    chk8({7'h0, o_interrupt}, 8'h00);
    rd(3'h4);
    chk8(d & 8'h0f, 8'h00);
  endtask : t_power

  // main sequence
  initial
  begin
    repeat (6) @(posedge i_clock);
    i_rst <= 1'b0;
    t_poll_int();
    t_results();
    t_step();
    t_power();
    end_sim();
  end
endmodule : floppy_drive_poll_and_result_status_bench
